// ---- inc/flash_ctl_pkg.sv ----
// constants for the flash program/erase mode control block
package flash_ctl_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [3:0] off_mode_control = 4'h0;
  localparam logic [3:0] off_fault_status = 4'h4;
  localparam logic [3:0] off_erase_select = 4'h8;
  localparam logic [3:0] off_access_gate = 4'hc;
  // ==========================================
  // mode control fields
  localparam int bit_reserved_top = 7;
  localparam int bit_sw_write_en = 6;
  localparam int bit_erase_setup = 5;
  localparam int bit_program_setup = 4;
  localparam int bit_erase_verify = 3;
  localparam int bit_program_verify = 2;
  localparam int bit_erase_run = 1;
  localparam int bit_program_run = 0;
  // ==========================================
  // other fields and widths
  localparam int bit_fault_flag = 7;
  localparam int bit_reg_access_on = 7;
  localparam int erase_blocks = 5;
  localparam int prog_unit_bytes = 128;
  localparam logic [7:0] mode_control_reset = 8'h00;
  localparam logic [4:0] erase_select_reset = 5'h00;
  localparam logic [15:0] flash_top_addr = 16'h4fff;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : flash_ctl_pkg

// ---- design/flash_program_erase_control.sv ----
// flash program/erase mode control with axi4-lite register slave
module flash_program_erase_control
  import flash_ctl_pkg::*;
#(
  parameter int addr_w = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // flash array side
  input wire logic boot_mode,
  input wire logic array_error,
  input wire logic [addr_w-1:0] array_addr,
  output logic array_program,
  output logic array_erase,
  output logic array_program_setup,
  output logic array_erase_setup,
  output logic array_program_verify,
  output logic array_erase_verify,
  output logic [erase_blocks-1:0] array_erase_blocks,
  output logic array_protected,
  output logic addr_unit_aligned
);

  // ==========================================
  // pin synchronisers
  logic [1:0] boot_sync;
  logic [1:0] err_sync;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      boot_sync <= 2'b00;
      err_sync <= 2'b00;
    end else begin
      boot_sync <= {boot_sync[0], boot_mode};
      err_sync <= {err_sync[0], array_error};
    end
  end

  // ==========================================
  // registers
  logic [7:0] mode_control;
  logic [4:0] erase_select;
  logic fault_flag;
  logic reg_access_on;

  // ==========================================
  // write channel: address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic aw_hole;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic [3:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic wr_hole;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr[3:0];
  assign wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
  assign wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
  assign wr_hole = aw_held ? aw_hole : (s_axi_awaddr[31:4] != 28'h0000000);
  assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready))
    && (w_held || (s_axi_wvalid && s_axi_wready));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      aw_hole <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[3:0];
        aw_hole <= s_axi_awaddr[31:4] != 28'h0000000;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  // decode; gated registers only reachable while access gate on
  logic wr_mapped;
  logic wr_gated_ok;
  // address bits above the map make a hole: error answer, no effect
  assign wr_mapped = !wr_hole && ((wr_addr == off_mode_control)
    || (wr_addr == off_fault_status) || (wr_addr == off_erase_select)
    || (wr_addr == off_access_gate));
  assign wr_gated_ok = reg_access_on || (wr_addr == off_access_gate);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = do_write && wr_lane0 && wr_gated_ok && wr_mapped;

  // ==========================================
  // access gate
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_access_on <= 1'b0;
    end else if (wr_en && wr_addr == off_access_gate) begin
      reg_access_on <= wr_byte[bit_reg_access_on];
    end
  end

  // ==========================================
  // mode control
  logic [7:0] next_mode;
  always_comb begin
    next_mode = mode_control;
    if (wr_en && wr_addr == off_mode_control) begin
      next_mode = wr_byte;
    end
    next_mode[bit_reserved_top] = 1'b0;
  end

  // write enable low or a fault clears the whole register; run needs its setup bit
  logic [7:0] gated_mode;
  always_comb begin
    gated_mode = next_mode;
    if (!gated_mode[bit_sw_write_en] || fault_flag) begin
      gated_mode = mode_control_reset;
    end
    if (!gated_mode[bit_erase_setup]) begin
      gated_mode[bit_erase_run] = 1'b0;
    end
    if (!gated_mode[bit_program_setup]) begin
      gated_mode[bit_program_run] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_control <= mode_control_reset;
    end else begin
      mode_control <= gated_mode;
    end
  end

  // ==========================================
  // erase block select
  logic [4:0] next_select;
  always_comb begin
    next_select = erase_select;
    if (wr_en && wr_addr == off_erase_select) begin
      next_select = wr_byte[erase_blocks-1:0];
    end
    if ($countones(next_select) > 1) begin
      next_select = erase_select_reset;
    end
    if (!mode_control[bit_sw_write_en] || fault_flag) begin
      next_select = erase_select_reset;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      erase_select <= erase_select_reset;
    end else begin
      erase_select <= next_select;
    end
  end

  // ==========================================
  // fault flag, sticky until reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fault_flag <= 1'b0;
    end else if (err_sync[1] && (array_program || array_erase)) begin
      fault_flag <= 1'b1;
    end
  end

  // ==========================================
  // array outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      array_program <= 1'b0;
      array_erase <= 1'b0;
      array_program_setup <= 1'b0;
      array_erase_setup <= 1'b0;
      array_program_verify <= 1'b0;
      array_erase_verify <= 1'b0;
      array_erase_blocks <= '0;
      array_protected <= 1'b0;
      addr_unit_aligned <= 1'b0;
    end else begin
      array_program <= mode_control[bit_program_run];
      array_erase <= mode_control[bit_erase_run];
      array_program_setup <= mode_control[bit_program_setup];
      array_erase_setup <= mode_control[bit_erase_setup];
      array_program_verify <= mode_control[bit_program_verify];
      array_erase_verify <= mode_control[bit_erase_verify];
      // boot loader erases all blocks; user mode only the one selected
      array_erase_blocks <= boot_sync[1] && mode_control[bit_erase_run]
        ? {erase_blocks{1'b1}} : erase_select;
      array_protected <= fault_flag;
      addr_unit_aligned <= (array_addr[6:0] == 7'h00)
        && ({{(32-addr_w){1'b0}}, array_addr} <= 32'(flash_top_addr));
    end
  end

  // ==========================================
  // read channel
  logic [7:0] rd_byte;
  logic rd_ok;
  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[3:0])
      off_mode_control: rd_byte = reg_access_on ? {1'b0, mode_control[6:0]} : 8'h00;
      off_fault_status: rd_byte = reg_access_on ? {fault_flag, 7'h00} : 8'h00;
      off_erase_select: rd_byte = reg_access_on ? {3'b000, erase_select} : 8'h00;
      off_access_gate: rd_byte = {reg_access_on, 7'h00};
      default: rd_ok = 1'b0;
    endcase
    if (s_axi_araddr[31:4] != 28'h0000000) begin
      rd_byte = 8'h00;
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_ok ? resp_okay : resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : flash_program_erase_control

// ---- dv/flash_program_erase_control_assertions.sv ----
// concurrent checks on the flash mode control block ports
module flash_pec_checker
  import flash_ctl_pkg::*;
#(
  parameter int addr_w = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // bus handshake
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // array side
  input wire logic [addr_w-1:0] array_addr,
  input wire logic array_program,
  input wire logic array_erase,
  input wire logic array_program_setup,
  input wire logic array_erase_setup,
  input wire logic [erase_blocks-1:0] array_erase_blocks,
  input wire logic array_protected,
  input wire logic addr_unit_aligned
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_wr_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_fault_held;
    array_protected ##1 array_protected;
  endsequence
  a_bvalid_holds: assert property (s_wr_wait |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_no_take_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_prog_setup: assert property (array_program |-> array_program_setup)
    else $error("program without program setup");
  a_erase_setup: assert property (array_erase |-> array_erase_setup)
    else $error("erase without erase setup");
  a_one_block: assert property ($onehot0(array_erase_blocks) || &array_erase_blocks)
    else $error("several erase blocks selected");
  a_fault_sticky: assert property (array_protected |=> array_protected)
    else $error("fault flag cleared");
  a_fault_stops: assert property (s_fault_held |-> !array_program && !array_erase)
    else $error("program or erase while protected");
  a_unit_align: assert property (arst_n |=> addr_unit_aligned ==
    ($past(array_addr[6:0]) == 7'h00 && $past(array_addr) <= flash_top_addr))
    else $error("unit alignment flag wrong");
endmodule : flash_pec_checker

bind flash_program_erase_control flash_pec_checker #(.addr_w(addr_w)) chk_u (.clk_sys,
  .arst_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .array_addr, .array_program, .array_erase,
  .array_program_setup, .array_erase_setup, .array_erase_blocks, .array_protected,
  .addr_unit_aligned);

// ---- dv/test_flash_program_erase_control.sv ----
// self-checking bench for the flash mode control block
module test_flash_program_erase_control
  import flash_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic boot_mode, array_error, array_program, array_erase, array_program_setup;
  logic array_erase_setup, array_program_verify, array_erase_verify;
  logic array_protected, addr_unit_aligned;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [15:0] array_addr;
  logic [erase_blocks-1:0] array_erase_blocks;
  int miscompares = 0;
  int num_checks = 0;
  localparam logic [15:0] al_a [5] = '{16'h0080, 16'h0081, 16'h4f80, 16'h5000, 16'h0040};
  localparam logic [4:0] al_e = 5'h05;
  always #5 clk_sys = ~clk_sys;
  flash_program_erase_control #(.addr_w(16)) dut_u (.clk_sys, .arst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .boot_mode,
    .array_error, .array_addr, .array_program, .array_erase, .array_program_setup,
    .array_erase_setup, .array_program_verify, .array_erase_verify, .array_erase_blocks,
    .array_protected, .addr_unit_aligned);
  // ==========
  // bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic aw, w, b;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      last_resp = s_axi_bresp;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    logic ar, r;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      last_resp = s_axi_rresp;
      @(posedge clk_sys);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask : rc
  task automatic settle;
    repeat (3) @(negedge clk_sys);
  endtask : settle
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // ==========
  // tests
  initial begin
    repeat (6000) @(posedge clk_sys);
    miscompares++;
    report_and_stop;
  end
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, boot_mode, array_error} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, array_addr} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    rc(32'h0, 32'h0);
    rc(32'h8, 32'h0);
    rd(32'h10, v);
    chk(last_resp, resp_slverr);
    wr(32'h0, 8'h40);
    wr(32'hc, 8'h80);
    rc(32'h0, 32'h0);
    wr(32'h10, 8'h7f);
    chk(last_resp, resp_slverr);
    rc(32'h0, 32'h0);
    wr(32'h0, 8'hff);
    chk(last_resp, resp_okay);
    rc(32'h0, 32'h7f);
    settle;
    chk({array_program, array_erase}, 32'h3);
    wr(32'h0, 8'h3f);
    rc(32'h0, 32'h0);
    s_axi_wstrb <= 4'he;
    wr(32'h0, 8'h7f);
    s_axi_wstrb <= 4'hf;
    rc(32'h0, 32'h0);
    for (int b = 2; b < 6; b++) begin
      wr(32'h0, 8'h40 | (8'h1 << b));
      rc(32'h0, 32'h40 | (32'h1 << b));
      settle;
      chk({array_erase_setup, array_program_setup, array_erase_verify,
        array_program_verify}, 32'h1 << (b - 2));
    end
    wr(32'h0, 8'h41);
    rc(32'h0, 32'h40);
    wr(32'h0, 8'h42);
    rc(32'h0, 32'h40);
    wr(32'h8, 8'h10);
    rc(32'h8, 32'h10);
    wr(32'h8, 8'h03);
    rc(32'h8, 32'h0);
    wr(32'h8, 8'h01);
    wr(32'h0, 8'h00);
    rc(32'h8, 32'h0);
    @(posedge clk_sys);
    boot_mode <= 1'b1;
    wr(32'h0, 8'h40);
    wr(32'h0, 8'h60);
    wr(32'h0, 8'h62);
    settle;
    chk(array_erase_blocks, 32'h1f);
    @(posedge clk_sys);
    boot_mode <= 1'b0;
    wr(32'h8, 8'h02);
    settle;
    chk(array_erase_blocks, 32'h2);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      array_addr <= al_a[i];
      settle;
      chk(addr_unit_aligned, al_e[i]);
    end
    wr(32'h0, 8'h50);
    wr(32'h0, 8'h51);
    @(posedge clk_sys);
    array_error <= 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(array_protected, 32'h1);
    @(posedge clk_sys);
    array_error <= 1'b0;
    rc(32'h4, 32'h80);
    wr(32'h4, 8'h00);
    wr(32'h0, 8'h50);
    wr(32'h0, 8'h51);
    settle;
    chk(array_program, 32'h0);
    rc(32'h4, 32'h80);
    report_and_stop;
  end
endmodule : test_flash_program_erase_control
